// File: rtl/dacr_pkg.sv
// Package for the dual converter serial register bank
package dacr_pkg;
  localparam logic [7:0] ADDR_PORT_SETUP = 8'h00;
  localparam logic [7:0] ADDR_PART_ID = 8'h01;
  localparam logic [7:0] ADDR_SPEED = 8'h02;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'h05;
  localparam logic [7:0] ADDR_POWER_MODES = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_OPT = 8'h09;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h0b;
  localparam logic [7:0] ADDR_COMMIT = 8'hff;
  localparam logic [7:0] RST_PORT_SETUP = 8'h18;
  localparam logic [7:0] RST_CHAN_SEL = 8'h03;
  localparam logic [7:0] RST_POWER_MODES = 8'h80;
  localparam logic [7:0] RST_CLOCK_OPT = 8'h00;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_COMMIT = 8'h00;
  localparam int SOFT_RST_HI = 5;
  localparam int SOFT_RST_LO = 2;
  localparam int LSB_FIRST_HI = 6;
  localparam int LSB_FIRST_LO = 1;
  localparam logic [7:0] SETUP_FIXED_ONES = 8'h18;
  localparam logic [7:0] MODES_MASK = 8'he3;
  localparam logic [7:0] CLOCK_OPT_MASK = 8'h01;
  localparam logic [7:0] CLK_DIV_MASK = 8'h07;
  localparam logic [7:0] CHAN_SEL_MASK = 8'h03;
  localparam int SPEED_LSB = 4;
  // Arbitrary neutral part identifier
  localparam logic [7:0] PART_ID_VALUE = 8'h5a;

  typedef struct packed {
    logic power_down_pin_en;
    logic [1:0] power_down_pin_mode;
    logic [1:0] power_mode;
  } dacr_modes_t;

  typedef struct packed {
    dacr_modes_t modes;
    logic duty_cycle_stabilizer;
    logic [2:0] clk_div_code;
  } dacr_chan_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } dacr_req_t;
endpackage : dacr_pkg

// File: rtl/dacr_chan_regs.sv
// Shadow and working copy of one channel's program registers
`timescale 1ns/1ps
module dacr_chan_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic commit_in,
  output logic [7:0] rd_data_out,
  output dacr_pkg::dacr_chan_cfg_t cfg_out
);
  logic [7:0] modes_q;
  logic [7:0] clock_q;
  logic [7:0] div_q;

  // Shadow storage; program writes wait for commit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      modes_q <= dacr_pkg::RST_POWER_MODES;
      clock_q <= dacr_pkg::RST_CLOCK_OPT;
      div_q <= dacr_pkg::RST_CLK_DIV;
    end else if (soft_rst_in) begin
      modes_q <= dacr_pkg::RST_POWER_MODES;
      clock_q <= dacr_pkg::RST_CLOCK_OPT;
      div_q <= dacr_pkg::RST_CLK_DIV;
    end else if (wr_en_in) begin
      case (addr_in)
        dacr_pkg::ADDR_POWER_MODES: modes_q <= data_in & dacr_pkg::MODES_MASK; // R7 R9
        dacr_pkg::ADDR_CLOCK_OPT: clock_q <= data_in & dacr_pkg::CLOCK_OPT_MASK; // R11 R9
        dacr_pkg::ADDR_CLK_DIV: div_q <= data_in & dacr_pkg::CLK_DIV_MASK; // R8 R9
        default: ;
      endcase
    end
  end

  // Working copy updated all at once
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_out <= '{modes: '{1'b1, 2'b00, 2'b00}, duty_cycle_stabilizer: 1'b0,
                   clk_div_code: 3'h0};
    end else if (soft_rst_in) begin
      cfg_out <= '{modes: '{1'b1, 2'b00, 2'b00}, duty_cycle_stabilizer: 1'b0,
                   clk_div_code: 3'h0};
    end else if (commit_in) begin
      cfg_out.modes.power_down_pin_en <= modes_q[7]; // R6
      cfg_out.modes.power_down_pin_mode <= modes_q[6:5];
      cfg_out.modes.power_mode <= modes_q[1:0];
      cfg_out.duty_cycle_stabilizer <= clock_q[0];
      cfg_out.clk_div_code <= div_q[2:0]; // R8
    end
  end

  always_comb begin
    case (addr_in)
      dacr_pkg::ADDR_POWER_MODES: rd_data_out = modes_q;
      dacr_pkg::ADDR_CLOCK_OPT: rd_data_out = clock_q;
      dacr_pkg::ADDR_CLK_DIV: rd_data_out = div_q;
      default: rd_data_out = 8'h00;
    endcase
  end
endmodule : dacr_chan_regs

// File: rtl/dacr_regs.sv
// Register bank top: chip setup, channel index, commit and two channel copies
// Functional notes
// R1 - Only the listed addresses and bits exist; all else reads zero and ignores writes.
// R2 - Setup register holds mirrored soft reset and LSB-first bits, bits 4:3 one, default 0x18.
// R3 - Address 0x01 returns a fixed read-only part identifier.
// R4 - Address 0x02 returns a read-only speed-grade field in its middle bits.
// R5 - Address 0x05 bits 0 and 1 pick channels A and B for writes, default 0x03; writes to 0x09 and 0x0B go to both channels.
// R6 - Writing bit 0 of 0xFF copies all shadow values to working registers at once.
// R7 - Address 0x08 holds power-down pin enable, pin mode and internal power mode, default 0x80.
// R8 - Address 0x0B low three bits set the clock divide code; ratio is code plus one.
// R9 - Writes to 0x08..0x0B stay shadowed until commit, and the commit bit self-clears.
// R10 - With both channels selected, a read returns channel A.
// R11 - Address 0x09 bit 0 enables the duty cycle stabilizer; register resets to zero.
`timescale 1ns/1ps
module dacr_regs #(
  parameter logic [1:0] SPEED_GRADE = 2'b11
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input dacr_pkg::dacr_req_t req_in,
  output logic [7:0] rd_data_out,
  output logic lsb_first_out,
  output dacr_pkg::dacr_chan_cfg_t cfg_a_out,
  output dacr_pkg::dacr_chan_cfg_t cfg_b_out
);
  logic [1:0] chan_sel_q;
  logic commit_q;
  logic soft_rst_q;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_d;
  logic commit_pulse;
  logic wr_a;
  logic wr_b;
  logic wr_prog;
  logic wr_glob;

  function automatic logic is_program(input logic [7:0] a);
    is_program = (a == dacr_pkg::ADDR_POWER_MODES) || (a == dacr_pkg::ADDR_CLOCK_OPT) ||
                 (a == dacr_pkg::ADDR_CLK_DIV);
  endfunction : is_program

  function automatic logic is_global(input logic [7:0] a);
    is_global = (a == dacr_pkg::ADDR_CLOCK_OPT) || (a == dacr_pkg::ADDR_CLK_DIV);
  endfunction : is_global

  assign commit_pulse = req_in.wr && (req_in.addr == dacr_pkg::ADDR_COMMIT) && req_in.data[0];
  // Global registers ignore the channel index so both copies stay equal
  assign wr_prog = req_in.wr && is_program(req_in.addr);
  assign wr_glob = wr_prog && is_global(req_in.addr);
  assign wr_a = wr_prog && (chan_sel_q[0] || wr_glob); // R5
  assign wr_b = wr_prog && (chan_sel_q[1] || wr_glob); // R5

  // Soft reset acts for one cycle, then clears itself
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= req_in.wr && (req_in.addr == dacr_pkg::ADDR_PORT_SETUP) &&
                    (req_in.data[dacr_pkg::SOFT_RST_HI] || req_in.data[dacr_pkg::SOFT_RST_LO]); // R2
    end
  end

  // Either mirrored copy sets LSB-first, so shift order cannot garble it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lsb_first_out <= 1'b0;
    end else if (soft_rst_q) begin
      lsb_first_out <= 1'b0;
    end else if (req_in.wr && req_in.addr == dacr_pkg::ADDR_PORT_SETUP) begin
      lsb_first_out <= req_in.data[dacr_pkg::LSB_FIRST_HI] ||
                       req_in.data[dacr_pkg::LSB_FIRST_LO]; // R2
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_sel_q <= dacr_pkg::RST_CHAN_SEL[1:0];
    end else if (soft_rst_q) begin
      chan_sel_q <= dacr_pkg::RST_CHAN_SEL[1:0];
    end else if (req_in.wr && req_in.addr == dacr_pkg::ADDR_CHAN_SEL) begin
      chan_sel_q <= req_in.data[1:0]; // R5
    end
  end

  // Commit bit is visible one cycle then autoclears
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= commit_pulse && !soft_rst_q; // R9
    end
  end

  dacr_chan_regs u_chan_a (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .soft_rst_in(soft_rst_q),
    .wr_en_in(wr_a),
    .addr_in(req_in.addr),
    .data_in(req_in.data),
    .commit_in(commit_pulse), // R6
    .rd_data_out(rd_a),
    .cfg_out(cfg_a_out)
  );

  dacr_chan_regs u_chan_b (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .soft_rst_in(soft_rst_q),
    .wr_en_in(wr_b),
    .addr_in(req_in.addr),
    .data_in(req_in.data),
    .commit_in(commit_pulse), // R6
    .rd_data_out(rd_b),
    .cfg_out(cfg_b_out)
  );

  always_comb begin
    case (req_in.addr)
      dacr_pkg::ADDR_PORT_SETUP: begin
        rd_d = dacr_pkg::SETUP_FIXED_ONES; // R2
        rd_d[dacr_pkg::LSB_FIRST_HI] = lsb_first_out;
        rd_d[dacr_pkg::LSB_FIRST_LO] = lsb_first_out;
      end
      dacr_pkg::ADDR_PART_ID: rd_d = dacr_pkg::PART_ID_VALUE; // R3
      dacr_pkg::ADDR_SPEED: rd_d = {2'b00, SPEED_GRADE, 4'h0} >> (4 - dacr_pkg::SPEED_LSB); // R4
      dacr_pkg::ADDR_CHAN_SEL: rd_d = {6'h00, chan_sel_q};
      dacr_pkg::ADDR_COMMIT: rd_d = {7'h00, commit_q};
      default: begin
        if (is_program(req_in.addr)) begin
          rd_d = chan_sel_q[0] ? rd_a : rd_b; // R10
        end else begin
          rd_d = 8'h00; // R1
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (req_in.rd) begin
      rd_data_out <= rd_d;
    end
  end
endmodule : dacr_regs

// File: verification/dacr_regs_checker.sv
// Port assertions for the register bank
`timescale 1ns/1ps
module dacr_regs_checker #(
  parameter logic [1:0] SPEED_GRADE = 2'b11
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input dacr_pkg::dacr_req_t req_in,
  input wire logic [7:0] rd_data_out,
  input wire logic lsb_first_out,
  input dacr_pkg::dacr_chan_cfg_t cfg_a_out,
  input dacr_pkg::dacr_chan_cfg_t cfg_b_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic sr;
  logic cm;
  assign sr = req_in.wr && req_in.addr == 8'h00 && (req_in.data[5] || req_in.data[2]);
  assign cm = req_in.wr && req_in.addr == 8'hff && req_in.data[0];
  sequence defaults_s;
    cfg_a_out == 9'h100 && cfg_b_out == 9'h100 && !lsb_first_out;
  endsequence
  id_read_a: assert property (
    req_in.rd && req_in.addr == 8'h01 |=> rd_data_out == dacr_pkg::PART_ID_VALUE)
    else $error("part id read wrong");
  grade_read_a: assert property (
    req_in.rd && req_in.addr == 8'h02 |=> rd_data_out == {2'b00, SPEED_GRADE, 4'h0})
    else $error("speed grade read wrong");
  open_read_a: assert property (
    req_in.rd && req_in.addr inside {8'h03, 8'h04, 8'h06, 8'h07} |=> rd_data_out == 8'h00)
    else $error("open address read not zero");
  commit_clear_a: assert property (
    req_in.rd && req_in.addr == 8'hff && !$past(cm) |=> rd_data_out == 8'h00)
    else $error("commit bit not cleared");
  lsb_mode_a: assert property (
    req_in.wr && req_in.addr == 8'h00 && !sr && req_in.data[6] == req_in.data[1]
    |=> lsb_first_out == $past(req_in.data[6]))
    else $error("lsb mode not applied");
  soft_reset_a: assert property (
    sr |-> ##2 defaults_s)
    else $error("soft reset left state");
  shadow_hold_a: assert property (
    !$past(cm) && !$past(sr) && !$past(sr, 2) |-> $stable(cfg_a_out) && $stable(cfg_b_out))
    else $error("config moved without commit");
  global_same_a: assert property (
    cfg_a_out.clk_div_code == cfg_b_out.clk_div_code
    && cfg_a_out.duty_cycle_stabilizer == cfg_b_out.duty_cycle_stabilizer)
    else $error("global fields differ");
endmodule : dacr_regs_checker
bind dacr_regs dacr_regs_checker #(.SPEED_GRADE(SPEED_GRADE)) dacr_regs_checker_inst (
  .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .rd_data_out(rd_data_out),
  .lsb_first_out(lsb_first_out), .cfg_a_out(cfg_a_out), .cfg_b_out(cfg_b_out));

// File: verification/dacr_host.sv
// Register host model driving single-byte requests
`timescale 1ns/1ps
module dacr_host (
  input wire logic clk_in,
  output dacr_pkg::dacr_req_t req_out
);
  initial req_out = '0;
  // Gap lets the bench act as a prompt or a slow host
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap);
    @(posedge clk_in);
    req_out <= '{w, !w, a, d};
    @(posedge clk_in);
    req_out <= '0;
    repeat (gap) @(posedge clk_in);
  endtask : xfer
endmodule : dacr_host

// File: verification/tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 0;
  logic rst_in = 1;
  dacr_pkg::dacr_req_t req;
  logic [7:0] rd;
  logic lsb;
  dacr_pkg::dacr_chan_cfg_t ca, cb;
  int fail_count = 0, n_compared = 0, sel;
  logic [7:0] v, sh8[2], wk8[2], g[4];
  logic [15:0] t[9] = '{16'h0018, 16'h015a, 16'h0210, 16'h0300, 16'h0503, 16'h0880,
    16'h0900, 16'h0b00, 16'hff00};
  dacr_regs #(.SPEED_GRADE(2'b01)) dacr_regs_inst (.clk_in(clk_in), .rst_in(rst_in),
    .req_in(req), .rd_data_out(rd), .lsb_first_out(lsb), .cfg_a_out(ca), .cfg_b_out(cb));
  dacr_host dacr_host_inst (.clk_in(clk_in), .req_out(req));
  initial forever #25 clk_in = ~clk_in;
  function automatic logic [8:0] ecfg(input int c);
    return {wk8[c][7:5], wk8[c][1:0], g[1][0], g[3][2:0]};
  endfunction : ecfg
  function automatic void mreset();
    sh8 = '{8'h80, 8'h80};
    wk8 = sh8;
    g = '{default: 8'h00};
  endfunction : mreset
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dacr_host_inst.xfer(1'b1, a, d, $urandom_range(1, 0));
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    dacr_host_inst.xfer(1'b0, a, 8'h00, 0);
    @(posedge clk_in);
    #1 chk("read", rd, e);
  endtask : rdc
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(90067));
    mreset();
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk("cfg_a", ca, ecfg(0));
    chk("cfg_b", cb, ecfg(1));
    foreach (t[i]) rdc(t[i][15:8], t[i][7:0]);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hff);
    rdc(8'h01, 8'h5a);
    rdc(8'h02, 8'h10);
    repeat (8) begin
      sel = $urandom_range(3, 1);
      v = $urandom;
      wr(8'h05, sel[7:0]);
      wr(8'h08, v);
      for (int c = 0; c < 2; c++) if (sel[c]) sh8[c] = v & 8'he3;
      v = $urandom;
      wr(8'h09, v);
      g[0] = v & 8'h01;
      v = $urandom;
      wr(8'h0b, v);
      g[2] = v & 8'h07;
      chk("held", ca, ecfg(0));
      wr(8'hff, 8'h01);
      wk8 = sh8;
      g[1] = g[0];
      g[3] = g[2];
      chk("cfg_a", ca, ecfg(0));
      chk("cfg_b", cb, ecfg(1));
      rdc(8'hff, 8'h00);
      rdc(8'h08, sh8[sel == 2]);
      rdc(8'h0b, g[3]);
    end
    wr(8'h00, 8'h42);
    chk("lsb", lsb, 9'h001);
    rdc(8'h00, 8'h5a);
    wr(8'h05, 8'h01);
    wr(8'h00, 8'h66);
    @(posedge clk_in);
    #1 mreset();
    chk("soft_a", ca, ecfg(0));
    chk("soft_b", cb, ecfg(1));
    chk("soft_lsb", lsb, 9'h000);
    rdc(8'h05, 8'h03);
    rdc(8'h00, 8'h18);
    rdc(8'h08, 8'h80);
    tally_and_finish();
  end
endmodule : tb_top
